// [hw/aam_map.svh]
`ifndef AAM_MAP_SVH
`define AAM_MAP_SVH
`define AAM_PC_RST 32'h0000_0000
`define AAM_VBR_RST 32'h000F_FC00
`define AAM_VEC_INIT_LO 32'h000F_FC00
`define AAM_VEC_INIT_HI 32'h000F_FFFF
`define AAM_DIR_BYTE_HI 32'h0000_00FF
`define AAM_DIR_HALF_HI 32'h0000_01FF
`define AAM_DIR_WORD_HI 32'h0000_03FF
`define AAM_REMAP_LO 32'h000C_0000
`define AAM_REMAP_HI 32'h000C_07FF
`define AAM_IO_HI 32'h0000_0FFF
`define AAM_IRAM_LO 32'h0001_0000
`define AAM_IRAM_HI 32'h0001_FFFF
`define AAM_IROM_LO 32'h0008_0000
`define AAM_IROM_HI 32'h000F_FFFF
`define AAM_DIV_STEPS 6'h20
`endif

// [hw/aam_pkg.sv]
package aam_pkg;
  typedef enum logic [1:0] {
    AAM_BYTE,
    AAM_HALF,
    AAM_WORD
  } aam_width_t;
  typedef enum logic [1:0] {
    AAM_ILEN16,
    AAM_ILEN32,
    AAM_ILEN48
  } aam_ilen_t;
  typedef enum logic [1:0] {
    AAM_MUL32,
    AAM_MUL16,
    AAM_DIVU
  } aam_mdop_t;
  typedef enum logic {
    AAM_MD_IDLE,
    AAM_MD_DIV
  } aam_mdst_t;
endpackage

// [hw/aam_md_if.sv]
`timescale 1ns/1ps
interface aam_md_if;
  logic start;
  aam_pkg::aam_mdop_t op;
  logic [31:0] a;
  logic [31:0] b;
  logic busy;
  logic done;
  logic [31:0] hi;
  logic [31:0] lo;
  modport core (
    output start,
    output op,
    output a,
    output b,
    input busy,
    input done,
    input hi,
    input lo
  );
  modport unit (
    input start,
    input op,
    input a,
    input b,
    output busy,
    output done,
    output hi,
    output lo
  );
endinterface

// [hw/aam_muldiv.sv]
`timescale 1ns/1ps
`include "aam_map.svh"
module aam_muldiv (
  input wire logic core_clk_i,
  input wire logic reset_i,
  aam_md_if.unit md
);
  aam_pkg::aam_mdst_t st_r;
  logic [5:0] cnt_r;
  logic [31:0] hi_r;
  logic [31:0] lo_r;
  logic [31:0] dvs_r;
  logic done_r;
  logic [32:0] shl_w;
  logic fits_w;
  logic [63:0] prod_w;
  logic [31:0] prod16_w;
  logic take_w;

  // Partial remainder shifted by one
  assign shl_w = {hi_r, lo_r[31]};
  assign fits_w = shl_w >= {1'b0, dvs_r};
  assign prod_w = {32'h0000_0000, md.a} * {32'h0000_0000, md.b};
  assign prod16_w = {16'h0000, md.a[15:0]} * {16'h0000, md.b[15:0]};
  assign take_w = md.start && (st_r == aam_pkg::AAM_MD_IDLE);
  assign md.busy = st_r != aam_pkg::AAM_MD_IDLE;
  assign md.done = done_r;
  assign md.hi = hi_r;
  assign md.lo = lo_r;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st_r <= aam_pkg::AAM_MD_IDLE;
      cnt_r <= 6'h00;
      hi_r <= 32'h0000_0000;
      lo_r <= 32'h0000_0000;
      dvs_r <= 32'h0000_0000;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (st_r)
        aam_pkg::AAM_MD_IDLE: begin
          if (take_w) begin
            case (md.op)
              aam_pkg::AAM_MUL32: begin
                hi_r <= prod_w[63:32];
                lo_r <= prod_w[31:0];
                done_r <= 1'b1;
              end
              aam_pkg::AAM_MUL16: begin
                lo_r <= prod16_w;
                done_r <= 1'b1;
              end
              default: begin
                hi_r <= 32'h0000_0000;
                lo_r <= md.a;
                dvs_r <= md.b;
                cnt_r <= `AAM_DIV_STEPS;
                st_r <= aam_pkg::AAM_MD_DIV;
              end
            endcase
          end
        end
        aam_pkg::AAM_MD_DIV: begin
          // One restoring step per cycle
          hi_r <= fits_w ? shl_w[31:0] - dvs_r : shl_w[31:0];
          lo_r <= {lo_r[30:0], fits_w};
          cnt_r <= cnt_r - 6'h01;
          if (cnt_r == 6'h01) begin
            st_r <= aam_pkg::AAM_MD_IDLE;
            done_r <= 1'b1;
          end
        end
        default: st_r <= aam_pkg::AAM_MD_IDLE;
      endcase
    end
  end

  AST_DIV_LATENCY: assert property (@(posedge core_clk_i) disable iff (reset_i) take_w && md.op == aam_pkg::AAM_DIVU |-> ##33 done_r) else $error("Division did not finish in 32 steps");
endmodule

// [hw/aam_core.sv]
`timescale 1ns/1ps
`include "aam_map.svh"
// Summary of operation
// - Multi-byte data stored most significant byte first
// - Bit 0 is the least significant bit
// - Sequential program counter advance keeps bit 0 clear
// - Odd branch target fetches from even address
// - Odd instruction addresses never raise exceptions
// - Word accesses clear two lowest address bits
// - Halfword accesses clear lowest address bit
// - Mask only the summed address, not operands
// - Direct I/O window 0FF, 1FF, 3FF by width
// - Initial vector table at 000FFC00 to 000FFFFF
// - Vector table follows writable base register
// - Flat linear 32-bit address space
// - Single-chip mode blocks external memory accesses
// - 0C0000 to 0C07FF decodes onto internal RAM
// - Fetch handles 16, 32 and 48 bit instructions
// - Loads and stores support byte, half, word
// - 32x32, 16x16 multiply and stepwise 32/32 divide
// - Vector base register resets to 000FFC00
module aam_core (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic single_chip_i,
  input wire logic fetch_adv_i,
  input wire aam_pkg::aam_ilen_t fetch_len_i,
  input wire logic branch_i,
  input wire logic [31:0] branch_target_i,
  output logic [31:0] program_counter_o,
  output logic [31:0] fetch_addr_o,
  input wire logic vbr_we_i,
  input wire logic vbr_clr_i,
  input wire logic [31:0] vbr_wdata_i,
  input wire logic [7:0] vec_num_i,
  output logic [31:0] vector_base_register_o,
  output logic [31:0] vec_addr_o,
  output logic vec_init_o,
  input wire logic acc_req_i,
  input wire logic acc_we_i,
  input wire aam_pkg::aam_width_t acc_width_i,
  input wire logic [31:0] base_i,
  input wire logic [31:0] index_i,
  input wire logic [31:0] wr_data_i,
  output logic acc_valid_o,
  output logic acc_we_o,
  output logic [31:0] acc_addr_o,
  output logic [3:0] acc_be_o,
  output logic [31:0] acc_wdata_o,
  output logic acc_blocked_o,
  output logic dir_io_o,
  output logic ram_remap_o,
  output logic [10:0] ram_offset_o,
  input wire logic rd_valid_i,
  input wire logic [31:0] rd_data_i,
  output logic load_valid_o,
  output logic [31:0] load_data_o,
  input wire logic md_start_i,
  input wire aam_pkg::aam_mdop_t md_op_i,
  input wire logic [31:0] md_a_i,
  input wire logic [31:0] md_b_i,
  output logic md_busy_o,
  output logic md_done_o,
  output logic [31:0] md_hi_o,
  output logic [31:0] md_lo_o
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] ilen_bytes(aam_pkg::aam_ilen_t l);
    case (l)
      aam_pkg::AAM_ILEN32: ilen_bytes = 32'h0000_0004;
      aam_pkg::AAM_ILEN48: ilen_bytes = 32'h0000_0006;
      default: ilen_bytes = 32'h0000_0002;
    endcase
  endfunction

  function automatic logic [31:0] align_ea(aam_pkg::aam_width_t w,
                                           logic [31:0] ea);
    case (w)
      aam_pkg::AAM_WORD: align_ea = {ea[31:2], 2'b00};
      aam_pkg::AAM_HALF: align_ea = {ea[31:1], 1'b0};
      default: align_ea = ea;
    endcase
  endfunction

  function automatic logic [31:0] dir_limit(aam_pkg::aam_width_t w);
    case (w)
      aam_pkg::AAM_WORD: dir_limit = `AAM_DIR_WORD_HI;
      aam_pkg::AAM_HALF: dir_limit = `AAM_DIR_HALF_HI;
      default: dir_limit = `AAM_DIR_BYTE_HI;
    endcase
  endfunction

  // Lane 3 carries the byte at the lowest address
  function automatic logic [3:0] lane_mask(aam_pkg::aam_width_t w,
                                           logic [1:0] off);
    case (w)
      aam_pkg::AAM_WORD: lane_mask = 4'hF;
      aam_pkg::AAM_HALF: lane_mask = off[1] ? 4'h3 : 4'hC;
      default: lane_mask = 4'h8 >> off;
    endcase
  endfunction

  function automatic logic in_range(logic [31:0] a, logic [31:0] lo,
                                    logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // ****************************************
  // Mode pin synchroniser
  // ****************************************
  logic sc_s1_r;
  logic sc_s2_r;
  logic sc_s3_r;
  logic sc_r;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sc_s1_r <= 1'b0;
      sc_s2_r <= 1'b0;
      sc_s3_r <= 1'b0;
      sc_r <= 1'b0;
    end else begin
      sc_s1_r <= single_chip_i;
      sc_s2_r <= sc_s1_r;
      sc_s3_r <= sc_s2_r;
      if (sc_s2_r == sc_s3_r) begin
        sc_r <= sc_s3_r;
      end
    end
  end

  // ****************************************
  // Program counter
  // ****************************************
  logic [31:0] pc_r;
  logic [31:0] pc_nxt;
  logic [31:0] pc_step;

  assign pc_step = pc_r + ilen_bytes(fetch_len_i);
  // Branch keeps an odd target as given
  assign pc_nxt = branch_i ? branch_target_i :
                  fetch_adv_i ? {pc_step[31:1], 1'b0} : pc_r;
  // No fault path exists for odd addresses
  assign fetch_addr_o = {pc_r[31:1], 1'b0};
  assign program_counter_o = pc_r;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pc_r <= `AAM_PC_RST;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  // ****************************************
  // Vector base
  // ****************************************
  logic [31:0] vbr_r;
  logic [31:0] vec_addr_r;

  always_ff @(posedge core_clk_i) begin
    if (reset_i || vbr_clr_i) begin
      vbr_r <= `AAM_VBR_RST;
    end else if (vbr_we_i) begin
      vbr_r <= vbr_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      vec_addr_r <= `AAM_VBR_RST;
    end else begin
      vec_addr_r <= vbr_r + {22'h00_0000, vec_num_i, 2'b00};
    end
  end

  assign vector_base_register_o = vbr_r;
  assign vec_addr_o = vec_addr_r;
  assign vec_init_o = in_range(vbr_r, `AAM_VEC_INIT_LO,
                               `AAM_VEC_INIT_HI);

  // ****************************************
  // Data address path
  // ****************************************
  logic [31:0] ea_w;
  logic [31:0] ea_al_w;
  logic ext_w;
  logic blocked_w;
  logic dir_w;
  logic remap_w;
  logic [3:0] be_w;
  logic [31:0] wdata_w;

  // Operands enter unmasked; only the sum is aligned
  assign ea_w = base_i + index_i;
  assign ea_al_w = align_ea(acc_width_i, ea_w);
  assign remap_w = in_range(ea_al_w, `AAM_REMAP_LO, `AAM_REMAP_HI);
  assign ext_w = !(ea_al_w <= `AAM_IO_HI) &&
                 !in_range(ea_al_w, `AAM_IRAM_LO, `AAM_IRAM_HI) &&
                 !in_range(ea_al_w, `AAM_IROM_LO, `AAM_IROM_HI);
  assign blocked_w = sc_r && ext_w;
  assign dir_w = ea_al_w <= dir_limit(acc_width_i);
  assign be_w = lane_mask(acc_width_i, ea_al_w[1:0]);
  // Replicate so the enabled lanes carry the operand
  assign wdata_w = (acc_width_i == aam_pkg::AAM_WORD) ? wr_data_i :
                   (acc_width_i == aam_pkg::AAM_HALF) ?
                   {2{wr_data_i[15:0]}} : {4{wr_data_i[7:0]}};

  logic acc_valid_r;
  logic acc_we_r;
  logic acc_blocked_r;
  logic [31:0] acc_addr_r;
  logic [3:0] acc_be_r;
  logic [31:0] acc_wdata_r;
  logic dir_r;
  logic remap_r;
  aam_pkg::aam_width_t ld_width_r;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      acc_valid_r <= 1'b0;
      acc_blocked_r <= 1'b0;
    end else begin
      acc_valid_r <= acc_req_i && !blocked_w;
      acc_blocked_r <= acc_req_i && blocked_w;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      acc_we_r <= 1'b0;
      acc_addr_r <= 32'h0000_0000;
      acc_be_r <= 4'h0;
      acc_wdata_r <= 32'h0000_0000;
      dir_r <= 1'b0;
      remap_r <= 1'b0;
      ld_width_r <= aam_pkg::AAM_BYTE;
    end else if (acc_req_i) begin
      acc_we_r <= acc_we_i;
      acc_addr_r <= ea_al_w;
      acc_be_r <= be_w;
      acc_wdata_r <= wdata_w;
      dir_r <= dir_w;
      remap_r <= remap_w;
      ld_width_r <= acc_width_i;
    end
  end

  assign acc_valid_o = acc_valid_r;
  assign acc_blocked_o = acc_blocked_r;
  assign acc_we_o = acc_we_r;
  assign acc_addr_o = acc_addr_r;
  assign acc_be_o = acc_be_r;
  assign acc_wdata_o = acc_wdata_r;
  assign dir_io_o = dir_r;
  assign ram_remap_o = remap_r;
  assign ram_offset_o = acc_addr_r[10:0];

  // ****************************************
  // Load return
  // ****************************************
  logic [7:0] ld_byte_w;
  logic [15:0] ld_half_w;
  logic [31:0] ld_w;
  logic load_valid_r;
  logic [31:0] load_data_r;

  // Lowest address sits in bits 31 to 24
  assign ld_byte_w = rd_data_i[8*(3-acc_addr_r[1:0]) +: 8];
  assign ld_half_w = acc_addr_r[1] ? rd_data_i[15:0] :
                     rd_data_i[31:16];
  assign ld_w = (ld_width_r == aam_pkg::AAM_WORD) ? rd_data_i :
                (ld_width_r == aam_pkg::AAM_HALF) ?
                {16'h0000, ld_half_w} :
                {24'h00_0000, ld_byte_w};

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      load_valid_r <= 1'b0;
      load_data_r <= 32'h0000_0000;
    end else begin
      load_valid_r <= rd_valid_i;
      if (rd_valid_i) begin
        load_data_r <= ld_w;
      end
    end
  end

  assign load_valid_o = load_valid_r;
  assign load_data_o = load_data_r;

  // ****************************************
  // Multiply and divide
  // ****************************************
  aam_md_if md ();

  assign md.start = md_start_i;
  assign md.op = md_op_i;
  assign md.a = md_a_i;
  assign md.b = md_b_i;
  assign md_busy_o = md.busy;
  assign md_done_o = md.done;
  assign md_hi_o = md.hi;
  assign md_lo_o = md.lo;

  aam_muldiv u_muldiv (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .md(md.unit)
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  AST_SEQ_PC_EVEN: assert property (fetch_adv_i && !branch_i |=> !pc_r[0]) else $error("Sequential PC odd");
  AST_BRANCH_ODD: assert property (branch_i |=> pc_r == $past(branch_target_i) && !fetch_addr_o[0]) else $error("Branch target mishandled");
  AST_NO_ODD_FETCH: assert property (fetch_addr_o == {pc_r[31:1], 1'b0}) else $error("Fetch address not even");
  AST_WORD_ALIGN: assert property (acc_req_i && !blocked_w && acc_width_i == aam_pkg::AAM_WORD |=> acc_valid_o && acc_addr_o == ($past(base_i + index_i) & 32'hFFFF_FFFC)) else $error("Word address not aligned");
  AST_HALF_ALIGN: assert property (acc_req_i && !blocked_w && acc_width_i == aam_pkg::AAM_HALF |=> acc_addr_o == ($past(base_i + index_i) & 32'hFFFF_FFFE)) else $error("Half address not aligned");
  AST_BYTE_RAW: assert property (acc_req_i && acc_width_i == aam_pkg::AAM_BYTE |=> acc_addr_o == $past(base_i + index_i) && acc_be_o == (4'h8 >> acc_addr_o[1:0])) else $error("Byte address altered");
  AST_SINGLE_BLOCK: assert property (acc_req_i && sc_r && ext_w |=> acc_blocked_o && !acc_valid_o) else $error("External access in single-chip mode");
  AST_REMAP: assert property (acc_valid_o && acc_addr_o >= `AAM_REMAP_LO && acc_addr_o <= `AAM_REMAP_HI |-> ram_remap_o && ram_offset_o == acc_addr_o[10:0]) else $error("Remap window missed");
  AST_VBR_CLR: assert property (vbr_clr_i |=> vbr_r == `AAM_VBR_RST ##1 vec_addr_r == `AAM_VBR_RST + {22'h00_0000, $past(vec_num_i), 2'b00}) else $error("Vector base not restored");
  AST_DIR_WIN: assert property (acc_req_i && acc_width_i == aam_pkg::AAM_WORD && ea_al_w == `AAM_DIR_WORD_HI - 32'h0000_0003 |=> dir_io_o) else $error("Direct window wrong");
  AST_MUL_RES: assert property (md_start_i && !md.busy && md_op_i == aam_pkg::AAM_MUL32 |=> md_done_o && {md_hi_o, md_lo_o} == {32'h0000_0000, $past(md_a_i)} * {32'h0000_0000, $past(md_b_i)}) else $error("Multiply result wrong");

  CV_ODD_BRANCH: cover property (branch_i && branch_target_i[0] ##1 fetch_adv_i);
  CV_BLOCKED: cover property (acc_blocked_o);
  CV_REMAP: cover property (acc_valid_o && ram_remap_o);
  CV_DIV_DONE: cover property (md_done_o && md_hi_o != 32'h0000_0000);
endmodule

// [verification/aam_mem_model.sv]
`timescale 1ns/1ps
module aam_mem_model (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic acc_valid_i,
  input wire logic acc_we_i,
  input wire logic [31:0] acc_addr_i,
  input wire logic [3:0] acc_be_i,
  input wire logic [31:0] acc_wdata_i,
  input wire logic [3:0] slow_i,
  output logic rd_valid_o,
  output logic [31:0] rd_data_o
);
  logic [31:0] mem_r [16];
  logic pend_r;
  logic [3:0] cnt_r;
  logic ret_w;
  initial begin
    rd_valid_o = 1'b0;
    rd_data_o = 32'h5A5A_A5A5;
    pend_r = 1'b0;
    cnt_r = 4'h0;
  end
  // Read answer once the wait count has run down
  assign ret_w = !reset_i && !(acc_valid_i && !acc_we_i) && pend_r &&
                 cnt_r == 4'h0;
  // Idle data toggles so a stale word never looks valid
  always @(negedge core_clk_i) begin
    rd_valid_o <= ret_w;
    rd_data_o <= ret_w ? mem_r[acc_addr_i[5:2]] : ~rd_data_o;
    if (acc_valid_i && acc_we_i) begin
      for (int i = 0; i < 4; i++) begin
        if (acc_be_i[i]) begin
          mem_r[acc_addr_i[5:2]][8*i+:8] <= acc_wdata_i[8*i+:8];
        end
      end
    end
    if (reset_i) begin
      pend_r <= 1'b0;
    end else if (acc_valid_i && !acc_we_i) begin
      pend_r <= 1'b1;
      cnt_r <= slow_i;
    end else if (pend_r && cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end else if (pend_r) begin
      pend_r <= 1'b0;
    end
  end
endmodule

// [verification/cpu_address_alignment_map_tb_top.sv]
`timescale 1ns/1ps
module cpu_address_alignment_map_tb_top;
  logic core_clk_i = 1'b0;
  logic reset_i, single_chip_i, fetch_adv_i, branch_i;
  aam_pkg::aam_ilen_t fetch_len_i;
  logic [31:0] branch_target_i, program_counter_o, fetch_addr_o;
  logic vbr_we_i, vbr_clr_i, vec_init_o;
  logic [31:0] vbr_wdata_i, vector_base_register_o, vec_addr_o;
  logic [7:0] vec_num_i;
  logic acc_req_i, acc_we_i, acc_valid_o, acc_we_o, acc_blocked_o;
  aam_pkg::aam_width_t acc_width_i;
  logic [31:0] base_i, index_i, wr_data_i, acc_addr_o, acc_wdata_o;
  logic [3:0] acc_be_o, slow;
  logic dir_io_o, ram_remap_o, rd_valid_i, load_valid_o;
  logic [10:0] ram_offset_o;
  logic [31:0] rd_data_i, load_data_o;
  logic md_start_i, md_busy_o, md_done_o;
  aam_pkg::aam_mdop_t md_op_i;
  logic [31:0] md_a_i, md_b_i, md_hi_o, md_lo_o;
  int failures, checked;
  aam_core dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .single_chip_i(single_chip_i), .fetch_adv_i(fetch_adv_i),
    .fetch_len_i(fetch_len_i), .branch_i(branch_i),
    .branch_target_i(branch_target_i), .program_counter_o(program_counter_o),
    .fetch_addr_o(fetch_addr_o), .vbr_we_i(vbr_we_i), .vbr_clr_i(vbr_clr_i),
    .vbr_wdata_i(vbr_wdata_i), .vec_num_i(vec_num_i),
    .vector_base_register_o(vector_base_register_o),
    .vec_addr_o(vec_addr_o), .vec_init_o(vec_init_o), .acc_req_i(acc_req_i),
    .acc_we_i(acc_we_i), .acc_width_i(acc_width_i), .base_i(base_i),
    .index_i(index_i), .wr_data_i(wr_data_i), .acc_valid_o(acc_valid_o),
    .acc_we_o(acc_we_o), .acc_addr_o(acc_addr_o), .acc_be_o(acc_be_o),
    .acc_wdata_o(acc_wdata_o), .acc_blocked_o(acc_blocked_o),
    .dir_io_o(dir_io_o), .ram_remap_o(ram_remap_o),
    .ram_offset_o(ram_offset_o), .rd_valid_i(rd_valid_i),
    .rd_data_i(rd_data_i), .load_valid_o(load_valid_o),
    .load_data_o(load_data_o), .md_start_i(md_start_i), .md_op_i(md_op_i),
    .md_a_i(md_a_i), .md_b_i(md_b_i), .md_busy_o(md_busy_o),
    .md_done_o(md_done_o), .md_hi_o(md_hi_o), .md_lo_o(md_lo_o));
  aam_mem_model mem (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .acc_valid_i(acc_valid_o), .acc_we_i(acc_we_o), .acc_addr_i(acc_addr_o),
    .acc_be_i(acc_be_o), .acc_wdata_i(acc_wdata_o), .slow_i(slow),
    .rd_valid_o(rd_valid_i), .rd_data_o(rd_data_i));
  // ****************
  // Helpers
  // ****************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  task automatic end_of_test;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic acc(input int w, input logic we, input logic [31:0] b,
                     input logic [31:0] x, input logic [31:0] d);
    acc_width_i = aam_pkg::aam_width_t'(w);
    acc_we_i = we;
    base_i = b;
    index_i = x;
    wr_data_i = d;
    // Request stays up so back-to-back calls keep it steady
    acc_req_i = 1'b1;
    cyc(1);
  endtask
  task automatic md(input int op, input logic [31:0] a, input logic [31:0] b);
    md_op_i = aam_pkg::aam_mdop_t'(op);
    md_a_i = a;
    md_b_i = b;
    md_start_i = 1'b1;
    cyc(1);
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic s_reset;
    chk(vector_base_register_o, 32'h000F_FC00);
    chk(vec_init_o, 32'h0000_0001);
  endtask
  task automatic s_fetch;
    logic [31:0] e;
    e = 32'h0000_0100;
    branch_target_i = 32'h0000_0101;
    branch_i = 1'b1;
    cyc(1);
    branch_i = 1'b0;
    chk(fetch_addr_o, e);
    for (int i = 0; i < 3; i++) begin
      fetch_len_i = aam_pkg::aam_ilen_t'(i);
      fetch_adv_i = 1'b1;
      e = e + 32'(2 * (i + 1));
      cyc(1);
      chk(program_counter_o, e);
    end
    fetch_adv_i = 1'b0;
  endtask
  task automatic s_vec;
    logic [31:0] v [4] = '{32'h000F_FFFF, 32'h0010_0000, 32'h000F_FBFF,
                           32'h000F_FC00};
    vec_num_i = 8'h05;
    vbr_wdata_i = 32'h0000_2000;
    vbr_we_i = 1'b1;
    cyc(1);
    vbr_we_i = 1'b0;
    chk(vector_base_register_o, 32'h0000_2000);
    cyc(1);
    chk(vec_addr_o, 32'h0000_2014);
    for (int i = 0; i < 4; i++) begin
      vbr_wdata_i = v[i];
      vbr_we_i = 1'b1;
      cyc(1);
      chk(vec_init_o, 32'(i != 1 && i != 2));
    end
    vbr_wdata_i = 32'h0000_3000;
    vbr_clr_i = 1'b1;
    cyc(1);
    vbr_we_i = 1'b0;
    vbr_clr_i = 1'b0;
    chk(vector_base_register_o, 32'h000F_FC00);
  endtask
  task automatic s_align;
    logic [31:0] ad [3] = '{32'h0000_1002, 32'h0000_1002, 32'h0000_1000};
    logic [3:0] be [3] = '{4'h2, 4'h3, 4'hF};
    logic [31:0] wd [3] = '{32'hD4D4_D4D4, 32'hC3D4_C3D4, 32'hA1B2_C3D4};
    for (int i = 0; i < 3; i++) begin
      acc(i, 1'b1, 32'h0000_1001, 32'h0000_0001, 32'hA1B2_C3D4);
      chk(acc_valid_o, 32'h0000_0001);
      chk(acc_we_o, 32'h0000_0001);
      chk(acc_addr_o, ad[i]);
      chk(acc_be_o, be[i]);
      chk(acc_wdata_o, wd[i]);
    end
    acc(2, 1'b1, 32'hFFFF_FFFF, 32'h0000_0003, 32'h0000_0000);
    chk(acc_addr_o, 32'h0000_0000);
  endtask
  task automatic s_dir;
    logic [31:0] ea [7] = '{32'h0000_00FF, 32'h0000_0100, 32'h0000_01FE,
      32'h0000_0200, 32'h0000_03FC, 32'h0000_0400, 32'h0000_01FF};
    int w [7] = '{0, 0, 1, 1, 2, 2, 1};
    logic [6:0] ex = 7'h55;
    for (int i = 0; i < 7; i++) begin
      acc(w[i], 1'b1, ea[i], 32'h0000_0000, 32'h0000_0000);
      chk(dir_io_o, 32'(ex[i]));
    end
  endtask
  task automatic s_remap;
    logic [31:0] ea [4] = '{32'h000C_0000, 32'h000C_07FF, 32'h000C_0800,
                            32'h000B_FFFF};
    for (int i = 0; i < 4; i++) begin
      acc(0, 1'b1, 32'h0000_0000, ea[i], 32'h0000_0000);
      chk(ram_remap_o, 32'(i < 2));
      chk(ram_offset_o, 32'(ea[i][10:0]));
    end
  endtask
  task automatic s_single;
    single_chip_i = 1'b1;
    acc_req_i = 1'b0;
    cyc(6);
    acc(0, 1'b1, 32'h0020_0000, 32'h0000_0000, 32'h0000_0000);
    chk({acc_blocked_o, acc_valid_o}, 32'h0000_0002);
    acc(0, 1'b1, 32'h000C_0000, 32'h0000_0000, 32'h0000_0000);
    chk({acc_blocked_o, acc_valid_o}, 32'h0000_0001);
    single_chip_i = 1'b0;
    acc_req_i = 1'b0;
    cyc(6);
    acc(0, 1'b1, 32'h0020_0000, 32'h0000_0000, 32'h0000_0000);
    chk({acc_blocked_o, acc_valid_o}, 32'h0000_0001);
  endtask
  task automatic s_load;
    logic [31:0] ea [5] = '{32'h0000_1010, 32'h0000_1013, 32'h0000_1012,
                            32'h0000_1011, 32'h0000_1013};
    logic [31:0] ex [5] = '{32'h0000_0011, 32'h0000_0044, 32'h0000_3344,
                            32'h0000_1122, 32'h1122_3344};
    int w [5] = '{0, 0, 1, 1, 2};
    int n;
    acc(2, 1'b1, 32'h0000_1010, 32'h0000_0000, 32'h1122_3344);
    for (int i = 0; i < 5; i++) begin
      slow = 4'(i * 2);
      acc(w[i], 1'b0, ea[i], 32'h0000_0000, 32'h0000_0000);
      acc_req_i = 1'b0;
      n = 0;
      while (load_valid_o !== 1'b1 && n < 20) begin
        cyc(1);
        n++;
      end
      chk(load_valid_o, 32'h0000_0001);
      chk(load_data_o, ex[i]);
    end
  endtask
  task automatic s_md;
    int n;
    md(0, 32'hFFFF_FFFF, 32'h0000_0002);
    chk(md_done_o, 32'h0000_0001);
    chk(md_hi_o, 32'h0000_0001);
    chk(md_lo_o, 32'hFFFF_FFFE);
    md(1, 32'h1234_FFFF, 32'h5678_0003);
    chk(md_lo_o, 32'h0002_FFFD);
    md(2, 32'h0000_0007, 32'h0000_0002);
    chk(md_busy_o, 32'h0000_0001);
    n = 1;
    while (md_done_o !== 1'b1 && n < 40) begin
      md_start_i = (n == 3);
      if (n == 3) begin
        md_a_i = 32'h0000_0064;
      end
      cyc(1);
      n++;
    end
    chk(n, 32'h0000_0021);
    chk(md_busy_o, 32'h0000_0000);
    chk(md_lo_o, 32'h0000_0003);
    chk(md_hi_o, 32'h0000_0001);
  endtask
  // ****************
  // Main sequence
  // ****************
  initial begin
    forever #50 core_clk_i = ~core_clk_i;
  end
  initial begin
    #(100 * 5000);
    failures++;
    end_of_test();
  end
  initial begin
    {single_chip_i, fetch_adv_i, branch_i, vbr_we_i, vbr_clr_i} = 5'h00;
    {acc_req_i, acc_we_i, md_start_i} = 3'h0;
    fetch_len_i = aam_pkg::AAM_ILEN16;
    acc_width_i = aam_pkg::AAM_BYTE;
    md_op_i = aam_pkg::AAM_MUL32;
    {branch_target_i, vbr_wdata_i, base_i, index_i} = 128'h0;
    {wr_data_i, md_a_i, md_b_i} = 96'h0;
    vec_num_i = 8'h00;
    slow = 4'h0;
    reset_i = 1'b1;
    cyc(5);
    reset_i = 1'b0;
    s_reset();
    s_fetch();
    s_vec();
    s_align();
    s_dir();
    s_remap();
    s_single();
    s_load();
    s_md();
    end_of_test();
  end
endmodule
